// >>> include/vof_pkg.sv
// Shared constants and types of the video output formatter
package vof_pkg;
    // Output formats
    localparam logic [1:0] FMT_444 = 2'h0;
    localparam logic [1:0] FMT_422 = 2'h1;
    localparam logic [1:0] FMT_DDR = 2'h2;
    // Output clock sources
    localparam logic [1:0] CS_PIX  = 2'h0;
    localparam logic [1:0] CS_P90  = 2'h1;
    localparam logic [1:0] CS_X2   = 2'h2;
    localparam logic [1:0] CS_TEST = 2'h3;
    // Quarter phases of one pixel period, gray ordered
    typedef enum logic [1:0] {
        PH_0 = 2'h0,
        PH_1 = 2'h1,
        PH_2 = 2'h3,
        PH_3 = 2'h2
    } vof_phase_t;
    // Pixel word layout {hsync, red, green, blue}
    localparam int PIX_W   = 31;
    localparam int HS_BIT  = 30;
    localparam int HALF_LO = 0;
    localparam int HALF_HI = 15;
    localparam int HALF_W  = 15;
    // Data sets shown before valid data after start or flush
    localparam logic [2:0] FILL_SETS = 3'h6;
    // Test clock, in kHz
    localparam longint TEST_CLK_KHZ = 40000;
    localparam int     NCO_W        = 16;
    // Reset values of the synchronised configuration
    localparam logic [6:0] CFG_RST = 7'h00;
endpackage : vof_pkg

// >>> hw/vof_async_fifo.sv
// Dual-clock FIFO with gray-coded pointers
`timescale 1ns/1ns
module vof_async_fifo #(
    parameter int W = 31,
    parameter int D = 16
) (
    input  wire logic         wclk_i,
    input  wire logic         wrst_n_i,
    input  wire logic         wvalid_i,
    input  wire logic [W-1:0] wdata_i,
    output logic              wready_o,
    input  wire logic         rclk_i,
    input  wire logic         rrst_n_i,
    output logic              rvalid_o,
    output logic [W-1:0]      rdata_o,
    input  wire logic         rready_i
);
    localparam int AW = $clog2(D);
    function automatic logic [AW:0] b2g(input logic [AW:0] b);
        b2g = b ^ (b >> 1);
    endfunction : b2g
    logic [W-1:0] mem [D];
    logic [AW:0] wb_reg, wg_reg, rq1_reg, rq2_reg, wb_next, wg_next;
    logic [AW:0] rb_reg, rg_reg, wq1_reg, wq2_reg, rb_next, rg_next;
    logic        wrdy_next, rvld_next;
    // Full compares against the read pointer with its top two bits turned
    always_comb begin
        wb_next   = wb_reg + {{AW{1'b0}}, wvalid_i & wready_o};
        wg_next   = b2g(wb_next);
        wrdy_next = wg_next != {~rq2_reg[AW:AW-1], rq2_reg[AW-2:0]};
        rb_next   = rb_reg + {{AW{1'b0}}, rvalid_o & rready_i};
        rg_next   = b2g(rb_next);
        rvld_next = rg_next != wq2_reg;
    end
    always_ff @(posedge wclk_i or negedge wrst_n_i) begin
        if (!wrst_n_i) begin
            {wb_reg, wg_reg, rq1_reg, rq2_reg} <= '0;
            wready_o <= 1'b0;
        end else begin
            {wb_reg, wg_reg} <= {wb_next, wg_next};
            {rq1_reg, rq2_reg} <= {rg_reg, rq1_reg};
            wready_o <= wrdy_next;
        end
    end
    // Storage has no reset; only written entries are ever read
    always_ff @(posedge wclk_i) begin
        if (wvalid_i && wready_o) begin
            mem[wb_reg[AW-1:0]] <= wdata_i;
        end
    end
    always_ff @(posedge rclk_i or negedge rrst_n_i) begin
        if (!rrst_n_i) begin
            {rb_reg, rg_reg, wq1_reg, wq2_reg} <= '0;
            rvalid_o <= 1'b0;
        end else begin
            {rb_reg, rg_reg} <= {rb_next, rg_next};
            {wq1_reg, wq2_reg} <= {wg_reg, wq1_reg};
            rvalid_o <= rvld_next;
        end
    end
    assign rdata_o = mem[rb_reg[AW-1:0]];
endmodule : vof_async_fifo

// >>> hw/vof_formatter.sv
// Video output formatter: pixel FIFO, format mux and output clock
`timescale 1ns/1ns
module vof_formatter #(
    parameter int     FIFO_D   = 16,
    parameter longint LINK_KHZ = 380000
) (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       link_clk_i,
    input  wire logic [9:0] pix_r_i,
    input  wire logic [9:0] pix_g_i,
    input  wire logic [9:0] pix_b_i,
    input  wire logic       pix_hs_i,
    input  wire logic       pix_valid_i,
    output logic            pix_ready_o,
    input  wire logic [1:0] fmt_i,
    input  wire logic [1:0] clk_sel_i,
    input  wire logic       clk_inv_i,
    input  wire logic       hs_pol_i,
    input  wire logic       flush_i,
    output logic [9:0]      red_o,
    output logic [9:0]      green_o,
    output logic [9:0]      blue_o,
    output logic            output_pixel_clock_o,
    output logic            aligned_hsync_out_o,
    output logic            data_valid_o
);
    // Test clock step for the accumulator; product needs 64 bits
    localparam logic [vof_pkg::NCO_W-1:0] NCO_INC =
        vof_pkg::NCO_W'((vof_pkg::TEST_CLK_KHZ << vof_pkg::NCO_W) / LINK_KHZ);

    logic                      lrst1_reg;
    logic                      lrst_n;
    logic [6:0]                cfg1_reg;
    logic [6:0]                cfg2_reg;
    logic [1:0]                fmt;
    logic [1:0]                sel;
    logic                      inv;
    logic                      hs_pol;
    logic                      flush;
    logic                      rd_valid;
    logic                      rd_ready;
    logic [vof_pkg::PIX_W-1:0] rd_data;
    vof_pkg::vof_phase_t       ph_reg;
    vof_pkg::vof_phase_t       ph_next;
    logic [vof_pkg::PIX_W-1:0] cur_reg;
    logic [vof_pkg::PIX_W-1:0] cur_next;
    logic                      hsp_reg;
    logic                      hsp_next;
    logic                      cr_reg;
    logic                      cr_next;
    logic [2:0]                fill_reg;
    logic [2:0]                fill_next;
    logic [vof_pkg::NCO_W-1:0] nco_reg;
    logic [vof_pkg::NCO_W-1:0] nco_next;
    logic [9:0]                red_next;
    logic [9:0]                green_next;
    logic [9:0]                blue_next;
    logic                      oclk_next;
    logic                      hso_next;
    logic                      dv_next;
    logic [9:0]                chroma;
    logic [vof_pkg::HALF_W-1:0] lo_half;
    logic [vof_pkg::HALF_W-1:0] hi_half;

    // Link-side reset: asserted at once, released on the link clock
    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lrst1_reg <= 1'b0;
            lrst_n    <= 1'b0;
        end else begin
            lrst1_reg <= 1'b1;
            lrst_n    <= lrst1_reg;
        end
    end

    // Static configuration crosses as levels through two flops.
    // Held by the pin reset, so it settles while the link logic is still in reset
    // and no pin ever shows the reset configuration mixed with the chosen one.
    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg1_reg <= vof_pkg::CFG_RST;
            cfg2_reg <= vof_pkg::CFG_RST;
        end else begin
            cfg1_reg <= {flush_i, hs_pol_i, clk_inv_i, clk_sel_i, fmt_i};
            cfg2_reg <= cfg1_reg;
        end
    end
    assign {flush, hs_pol, inv, sel, fmt} = cfg2_reg;

    // Pixels cross into the link domain here; the drain takes one
    // word per pixel period, so a faster source is held off by ready
    vof_async_fifo #(
        .W (vof_pkg::PIX_W),
        .D (FIFO_D)
    ) u_fifo (
        .wclk_i   (clk_i),
        .wrst_n_i (arst_n_i),
        .wvalid_i (pix_valid_i),
        .wdata_i  ({pix_hs_i, pix_r_i, pix_g_i, pix_b_i}),
        .wready_o (pix_ready_o),
        .rclk_i   (link_clk_i),
        .rrst_n_i (lrst_n),
        .rvalid_o (rd_valid),
        .rdata_o  (rd_data),
        .rready_i (rd_ready)
    );

    // Link clock runs at four times the pixel rate: one quarter per tick
    always_comb begin
        case (ph_reg)
            vof_pkg::PH_0: ph_next = vof_pkg::PH_1;
            vof_pkg::PH_1: ph_next = vof_pkg::PH_2;
            vof_pkg::PH_2: ph_next = vof_pkg::PH_3;
            default:       ph_next = vof_pkg::PH_0;
        endcase
    end
    assign rd_ready = (ph_reg == vof_pkg::PH_3);

    // Pixel fetch, chroma order and fill count
    always_comb begin
        cur_next  = cur_reg;
        hsp_next  = hsp_reg;
        cr_next   = cr_reg;
        fill_next = fill_reg;
        if (flush) begin
            fill_next = 3'h0;
        end else if (rd_ready && rd_valid) begin
            cur_next = rd_data;
            hsp_next = cur_reg[vof_pkg::HS_BIT];
            // Hsync just ended: restart chroma with Cb
            if (cur_reg[vof_pkg::HS_BIT] && !rd_data[vof_pkg::HS_BIT]) begin
                cr_next = 1'b0;
            end else begin
                cr_next = !cr_reg;
            end
            // Counts one past the fill sets: the word after them is the first valid one
            if (fill_reg != vof_pkg::FILL_SETS + 3'h1) begin
                fill_next = fill_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge link_clk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            ph_reg   <= vof_pkg::PH_3;
            cur_reg  <= '0;
            hsp_reg  <= 1'b0;
            cr_reg   <= 1'b1;
            fill_reg <= 3'h0;
        end else begin
            ph_reg   <= ph_next;
            cur_reg  <= cur_next;
            hsp_reg  <= hsp_next;
            cr_reg   <= cr_next;
            fill_reg <= fill_next;
        end
    end

    // Halves of the 30-bit word and the chroma of this pixel
    assign lo_half = cur_next[vof_pkg::HALF_LO +: vof_pkg::HALF_W];
    assign hi_half = cur_next[vof_pkg::HALF_HI +: vof_pkg::HALF_W];
    assign chroma  = cr_next ? cur_next[29:20] : cur_next[9:0];

    // Output clock and data; all pins change only on quarter edges.
    // Test clock is an accumulator, so it carries link-rate jitter.
    always_comb begin
        nco_next   = nco_reg + NCO_INC;
        red_next   = red_o;
        green_next = green_o;
        blue_next  = blue_o;
        hso_next   = aligned_hsync_out_o;
        dv_next    = (fill_next == vof_pkg::FILL_SETS + 3'h1);
        case (sel)
            vof_pkg::CS_PIX: oclk_next = (ph_next == vof_pkg::PH_0) || (ph_next == vof_pkg::PH_1);
            vof_pkg::CS_P90: oclk_next = (ph_next == vof_pkg::PH_1) || (ph_next == vof_pkg::PH_2);
            vof_pkg::CS_X2:  oclk_next = (ph_next == vof_pkg::PH_0) || (ph_next == vof_pkg::PH_2);
            default:         oclk_next = nco_next[vof_pkg::NCO_W-1];
        endcase
        oclk_next = oclk_next ^ inv;
        if (ph_next == vof_pkg::PH_0) begin
            // Rising half: DDR low half and secondary chroma
            if (fmt == vof_pkg::FMT_DDR) begin
                red_next   = lo_half[14:5];
                green_next = {lo_half[4:0], 5'h00};
            end
            if (fmt != vof_pkg::FMT_444) begin
                blue_next = chroma;
            end
        end else if (ph_next == vof_pkg::PH_2) begin
            // Falling half: parallel words, DDR high half, luma
            hso_next = cur_next[vof_pkg::HS_BIT] ^ hs_pol;
            case (fmt)
                vof_pkg::FMT_422: begin
                    red_next   = chroma;
                    green_next = cur_next[19:10];
                    blue_next  = cur_next[19:10];
                end
                vof_pkg::FMT_DDR: begin
                    red_next   = hi_half[14:5];
                    green_next = {hi_half[4:0], 5'h00};
                    blue_next  = cur_next[19:10];
                end
                default: begin
                    red_next   = cur_next[29:20];
                    green_next = cur_next[19:10];
                    blue_next  = cur_next[9:0];
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            nco_reg              <= '0;
            red_o                <= 10'h000;
            green_o              <= 10'h000;
            blue_o               <= 10'h000;
            output_pixel_clock_o <= 1'b0;
            aligned_hsync_out_o  <= 1'b0;
            data_valid_o         <= 1'b0;
        end else begin
            nco_reg              <= nco_next;
            red_o                <= red_next;
            green_o              <= green_next;
            blue_o               <= blue_next;
            output_pixel_clock_o <= oclk_next;
            aligned_hsync_out_o  <= hso_next;
            data_valid_o         <= dv_next;
        end
    end

    // Checks on the link side
    property p_clk_pix;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (sel == vof_pkg::CS_PIX && !inv && ph_reg == vof_pkg::PH_3)
            |=> output_pixel_clock_o ##1 output_pixel_clock_o ##1 !output_pixel_clock_o;
    endproperty
    a_clk_pix: assert property (p_clk_pix) else $error("pixel clock shape wrong");

    property p_clk_inv;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (sel == vof_pkg::CS_P90 && inv && ph_reg == vof_pkg::PH_0)
            |=> !output_pixel_clock_o ##1 !output_pixel_clock_o;
    endproperty
    a_clk_inv: assert property (p_clk_inv) else $error("inverted clock wrong");

    property p_444;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (fmt == vof_pkg::FMT_444 && ph_reg == vof_pkg::PH_1)
            |=> {red_o, green_o, blue_o} == cur_reg[29:0];
    endproperty
    a_444: assert property (p_444) else $error("parallel word wrong");

    property p_422;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (fmt == vof_pkg::FMT_422 && ph_reg == vof_pkg::PH_3)
            |-> green_o == cur_reg[19:10] && blue_o == cur_reg[19:10];
    endproperty
    a_422: assert property (p_422) else $error("luma placement wrong");

    property p_sec;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (fmt != vof_pkg::FMT_444 && ph_reg == vof_pkg::PH_1)
            |-> blue_o == (cr_reg ? cur_reg[29:20] : cur_reg[9:0]);
    endproperty
    a_sec: assert property (p_sec) else $error("secondary chroma wrong");

    property p_ddr_lo;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (fmt == vof_pkg::FMT_DDR && ph_reg == vof_pkg::PH_0)
            |-> {red_o, green_o[9:5]} == cur_reg[14:0];
    endproperty
    a_ddr_lo: assert property (p_ddr_lo) else $error("low half wrong");

    property p_ddr_hi;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (fmt == vof_pkg::FMT_DDR && ph_reg == vof_pkg::PH_2)
            |-> {red_o, green_o[9:5]} == {cur_reg[29:20], cur_reg[19:15]};
    endproperty
    a_ddr_hi: assert property (p_ddr_hi) else $error("high half wrong");

    property p_cb_first;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (ph_reg == vof_pkg::PH_0 && hsp_reg && !cur_reg[vof_pkg::HS_BIT])
            |-> !cr_reg;
    endproperty
    a_cb_first: assert property (p_cb_first) else $error("first chroma not Cb");

    property p_fill;
        @(posedge link_clk_i) disable iff (!lrst_n)
        $rose(data_valid_o) |-> $past(fill_reg) == vof_pkg::FILL_SETS;
    endproperty
    a_fill: assert property (p_fill) else $error("valid before six sets");

    property p_hs;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (ph_reg == vof_pkg::PH_2)
            |-> aligned_hsync_out_o == (cur_reg[vof_pkg::HS_BIT] ^ $past(hs_pol));
    endproperty
    a_hs: assert property (p_hs) else $error("hsync out misaligned");
endmodule : vof_formatter

// >>> dv/vof_rx_model.sv
// Receiver model that captures formatter pins with the supplied clock
`timescale 1ns/1ns
module vof_rx_model (
    input  wire logic       ock_i,
    input  wire logic       valid_i,
    input  wire logic [9:0] red_i,
    input  wire logic [9:0] green_i,
    input  wire logic [9:0] blue_i,
    input  wire logic       hs_i,
    output logic [9:0]      rr_o,
    output logic [9:0]      rg_o,
    output logic [9:0]      rb_o,
    output logic [9:0]      fr_o,
    output logic [9:0]      fg_o,
    output logic [9:0]      fb_o,
    output logic            fhs_o,
    output int              cnt_o
);
    initial cnt_o = 0;
    // Rising half; the shifted clock samples mid-eye, away from both pin edges
    always @(posedge ock_i) begin
        rr_o <= red_i;
        rg_o <= green_i;
        rb_o <= blue_i;
    end
    // Falling half closes a pixel, counted only once data is flagged valid
    always @(negedge ock_i) begin
        if (valid_i) begin
            fr_o  <= red_i;
            fg_o  <= green_i;
            fb_o  <= blue_i;
            fhs_o <= hs_i;
            cnt_o <= cnt_o + 1;
        end
    end
endmodule : vof_rx_model

// >>> dv/tb_vof_formatter.sv
// Self-checking bench of the video output formatter
`timescale 1ns/1ns
module tb_vof_formatter;
    localparam longint LINK_KHZ = 160000; // Puts the test clock at a quarter of the link rate
    typedef struct packed {logic hs; logic cb; logic [9:0] r; logic [9:0] g; logic [9:0] b;} vof_exp_t;
    logic        clk_i = 0, arst_n_i = 0, link_clk_i = 0, pix_hs_i = 0, pix_valid_i = 0;
    logic        clk_inv_i = 0, hs_pol_i = 0, flush_i = 0, exp_en = 0, cb = 1, seen_full = 0, mon_en = 0, prev;
    logic [9:0]  pix_r_i = 0, pix_g_i = 0, pix_b_i = 0, red_o, green_o, blue_o, rr, rg, rb, fr, fg, fb, c, g_prev;
    logic [1:0]  fmt_i = 0, clk_sel_i = 0;
    logic        pix_ready_o, output_pixel_clock_o, aligned_hsync_out_o, data_valid_o, fhs;
    logic [31:0] lfsr = 32'h3426;
    logic [29:0] w;
    logic [3:0]  pat;
    int          error_cnt = 0, n_tests = 0, cap_cnt, wr_cnt = 0, n_wr = 0, rises;
    vof_exp_t    exp_q[$];
    vof_exp_t    e;

    initial forever #2 clk_i = ~clk_i;
    // Odd offset keeps the link clock unrelated in phase
    initial begin
        #7;
        forever #32 link_clk_i = ~link_clk_i;
    end

    vof_formatter #(.FIFO_D(16), .LINK_KHZ(LINK_KHZ)) vof_formatter_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .link_clk_i(link_clk_i), .pix_r_i(pix_r_i), .pix_g_i(pix_g_i), .pix_b_i(pix_b_i), .pix_hs_i(pix_hs_i),
        .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .fmt_i(fmt_i), .clk_sel_i(clk_sel_i),
        .clk_inv_i(clk_inv_i), .hs_pol_i(hs_pol_i), .flush_i(flush_i), .red_o(red_o), .green_o(green_o),
        .blue_o(blue_o), .output_pixel_clock_o(output_pixel_clock_o), .aligned_hsync_out_o(aligned_hsync_out_o),
        .data_valid_o(data_valid_o));
    vof_rx_model vof_rx_model_inst (.ock_i(output_pixel_clock_o), .valid_i(data_valid_o), .red_i(red_o),
        .green_i(green_o), .blue_i(blue_o), .hs_i(aligned_hsync_out_o), .rr_o(rr), .rg_o(rg), .rb_o(rb),
        .fr_o(fr), .fg_o(fg), .fb_o(fb), .fhs_o(fhs), .cnt_o(cap_cnt));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Clock level sampled at the 4:4:4 change edge and the three link ticks after it
    function automatic logic [3:0] shape(input logic [1:0] sel);
        return (sel == vof_pkg::CS_PIX) ? 4'h3 : (sel == vof_pkg::CS_P90) ? 4'h9 : 4'hA;
    endfunction : shape

    task automatic check(input string what, input logic [29:0] seen, input logic [29:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // Source: writes while the buffer accepts; model state clears with reset so no race with main
    always @(posedge clk_i) begin
        if (!arst_n_i) begin
            wr_cnt = 0;
            cb = 1;
            seen_full = 0;
        end
        if (pix_valid_i && !pix_ready_o) seen_full = 1;
        if (pix_valid_i && pix_ready_o) begin
            if (exp_en && wr_cnt >= vof_pkg::FILL_SETS) exp_q.push_back({pix_hs_i, cb, pix_r_i, pix_g_i, pix_b_i});
            cb = pix_hs_i ? 1'b1 : ~cb;
            wr_cnt++;
            lfsr = lfsr_next(lfsr);
            pix_r_i <= lfsr[9:0];
            pix_g_i <= lfsr[19:10];
            pix_b_i <= lfsr[29:20];
            pix_hs_i <= (lfsr[31:30] == 2'h0);
        end
        pix_valid_i <= arst_n_i && (wr_cnt < n_wr);
    end

    // Observer: each captured pixel is matched against the oldest note
    always @(cap_cnt) if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        w = {e.r, e.g, e.b};
        c = e.cb ? e.b : e.r;
        check("hsync", 30'(fhs), 30'(e.hs ^ hs_pol_i));
        if (fmt_i == vof_pkg::FMT_444) begin
            check("rgb444", {fr, fg, fb}, w);
        end else if (fmt_i == vof_pkg::FMT_422) begin
            check("luma422", 30'(fg), 30'(e.g));
            if (!e.hs) check("chroma422", 30'(fr), 30'(c));
        end else begin
            check("ddr_lo", 30'({rr, rg[9:5]}), 30'(w[14:0]));
            check("ddr_hi", 30'({fr, fg[9:5]}), 30'(w[29:15]));
            check("ddr_pad", 30'({rg[4:0], fg[4:0]}), 30'h0);
        end
        if (fmt_i != vof_pkg::FMT_444) begin
            check("sec_luma", 30'(fb), 30'(e.g));
            if (!e.hs) check("sec_chroma", 30'(rb), 30'(c));
        end
    end

    // Output clock shape, judged from each 4:4:4 data change
    always begin
        @(posedge link_clk_i);
        #1;
        if (mon_en && green_o !== g_prev) begin
            pat = 4'h0;
            for (int k = 0; k < 4; k++) begin
                if (k > 0) begin
                    @(posedge link_clk_i);
                    #1;
                end
                pat = {pat[2:0], output_pixel_clock_o};
            end
            check("clk_shape", 30'(pat), 30'(shape(clk_sel_i) ^ {4{clk_inv_i}}));
        end
        g_prev = green_o;
    end

    // Reset with static configuration, then let it settle in the link domain
    task automatic start(input logic [1:0] fmt, input logic [1:0] sel, input logic inv, input logic pol,
                         input int n, input logic ex);
        mon_en = 0;
        repeat (4) @(posedge link_clk_i);
        @(posedge clk_i);
        arst_n_i <= 0;
        fmt_i <= fmt;
        clk_sel_i <= sel;
        clk_inv_i <= inv;
        hs_pol_i <= pol;
        n_wr <= n;
        exp_en <= ex;
        repeat (4) @(posedge link_clk_i);
        exp_q.delete();
        check("rst_pins", {red_o, green_o, blue_o}, 30'h0);
        @(posedge clk_i);
        arst_n_i <= 1;
        repeat (4) @(posedge link_clk_i);
        mon_en = (fmt == vof_pkg::FMT_444) && (sel != vof_pkg::CS_TEST);
    endtask : start

    initial begin
        for (int f = 0; f < 3; f++) begin
            start(2'(f), vof_pkg::CS_P90, 1'b0, 1'(f), 40, 1'b1);
            repeat (400) if (!(wr_cnt >= n_wr && exp_q.size() == 0)) @(posedge link_clk_i);
            check("drained", 30'(exp_q.size()), 30'h0);
            check("full_seen", 30'(seen_full), 30'h1);
        end
        // Flush: valid drops while held, returns only after six fresh pixels
        start(vof_pkg::FMT_444, vof_pkg::CS_P90, 1'b0, 1'b0, 60, 1'b0);
        repeat (100) if (data_valid_o !== 1'b1) @(posedge link_clk_i);
        check("valid_up", 30'(data_valid_o), 30'h1);
        @(posedge clk_i);
        flush_i <= 1;
        repeat (6) @(posedge link_clk_i);
        #1;
        check("valid_flush", 30'(data_valid_o), 30'h0);
        @(posedge clk_i);
        flush_i <= 0;
        repeat (4 * (vof_pkg::FILL_SETS - 1)) @(posedge link_clk_i);
        #1;
        check("valid_early", 30'(data_valid_o), 30'h0);
        repeat (12) @(posedge link_clk_i);
        #1;
        check("valid_late", 30'(data_valid_o), 30'h1);
        // Pixel, shifted and doubled clocks, each plain and inverted
        for (int s = 0; s < 3; s++) for (int i = 0; i < 2; i++) begin
            start(vof_pkg::FMT_444, 2'(s), 1'(i), 1'b0, 14, 1'b0);
            repeat (72) @(posedge link_clk_i);
        end
        // Test clock rate over a fixed link window; a one-edge slack covers window phase
        start(vof_pkg::FMT_444, vof_pkg::CS_TEST, 1'b0, 1'b0, 0, 1'b0);
        rises = 0;
        prev = output_pixel_clock_o;
        repeat (64) begin
            @(posedge link_clk_i);
            #1;
            if (output_pixel_clock_o === 1'b1 && prev === 1'b0) rises++;
            prev = output_pixel_clock_o;
        end
        check("test_clk", 30'(rises >= vof_pkg::TEST_CLK_KHZ * 64 / LINK_KHZ - 1 &&
                              rises <= vof_pkg::TEST_CLK_KHZ * 64 / LINK_KHZ + 1), 30'h1);
        report_and_stop();
    end

    // Watchdog sized well beyond the expected run of about 19000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        $display("[FAIL] watchdog expired");
        report_and_stop();
    end
endmodule : tb_vof_formatter
